// *** usart_rx_sampling_sync_master_tx.sv ***
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "usart_consts.svh"

module usart_rx_sampling_sync_master_tx (
   // system
   input  wire logic                clk,
   input  wire logic                reset,
   // register port
   input  wire usart_pkg::reg_req_t req,
   output      logic [7:0]          rdata,
   // data pin
   input  wire logic                dt_in,
   output      usart_pkg::pin_out_t dt_drv,
   // clock pin, output only in master mode
   output      usart_pkg::pin_out_t ck_drv,
   // interrupt request
   output      logic                irq
);
   import usart_pkg::*;

   state_t     s;
   state_t     n;
   logic       line;
   logic       lvl;
   logic       rx_on;
   logic       sync_rx;
   logic       tx_mode;
   logic       rx_ovr;
   logic       word_done;
   logic       pop;
   logic [3:0] rx_bits;
   logic [3:0] tx_bits;
   logic [8:0] shifted;
   rx_word_t   word;

   function automatic rx_word_t pack_word(input logic [8:0] v, input logic nine,
                                          input logic framing_error);
      rx_word_t w;
      w.framing_error  = framing_error;
      w.ninth = nine & v[8];
      w.data  = nine ? v[7:0] : v[8:1];
      return w;
   endfunction

   assign line = s.dt_sync[1];

   always_comb begin
      n         = s;
      rx_ovr    = s.continuous_receive_enable | s.single_receive_enable;
      tx_mode   = s.port_enable & s.sync & s.clock_source_master & s.transmit_enable;
      sync_rx   = s.port_enable & s.sync & s.clock_source_master & rx_ovr;
      rx_on     = s.port_enable & ~s.sync & s.continuous_receive_enable;
      rx_bits   = s.rx9 ? `BITS_LONG : `BITS_SHORT;
      tx_bits   = s.tx9 ? `BITS_LONG : `BITS_SHORT;
      lvl       = (s.votes[1] & s.votes[0]) | (s.votes[1] & line)
                | (s.votes[0] & line);
      shifted   = {line, s.rx_shift_register[8:1]};
      word_done = 1'b0;
      word      = '0;
      pop       = req.rd && (req.addr == `OFF_RX_DATA) && (s.fcnt != 2'h0);
      n.dt_sync = {s.dt_sync[0], dt_in};

      // baud generator
      n.tick = 1'b0;
      if (!(s.transmit_enable | rx_ovr)) begin
         n.baud_cnt = s.baud_div;
      end else if (s.baud_cnt == 8'h00) begin
         n.baud_cnt = s.baud_div;
         n.tick     = 1'b1;
      end else begin
         n.baud_cnt = s.baud_cnt - 8'h01;
      end

      // asynchronous receive, tick is the x16 clock
      if (s.tick && rx_on) begin
         n.ovs = s.ovs + 4'h1;
         if (s.ovs >= `SAMPLE_FIRST && s.ovs < `SAMPLE_LAST) begin
            n.votes = {s.votes[0], line};
         end
         case (s.rx_st)
            rx_idle: begin
               if (!line) begin
                  n.ovs   = 4'h1;
                  n.rx_st = rx_start;
               end
            end
            rx_start: begin
               if (s.ovs == `SAMPLE_LAST) begin
                  n.rx_st  = lvl ? rx_idle : rx_data;
                  n.rx_cnt = 4'h0;
               end
            end
            default: begin
               if (s.ovs == `SAMPLE_LAST) begin
                  if (s.rx_cnt != rx_bits) begin
                     n.rx_shift_register    = {lvl, s.rx_shift_register[8:1]};
                     n.rx_cnt = s.rx_cnt + 4'h1;
                  end else begin
                     word_done = 1'b1;
                     word      = pack_word(s.rx_shift_register, s.rx9, ~lvl);
                     n.rx_st   = rx_idle;
                  end
               end
            end
         endcase
      end

      // synchronous master shift clock
      if (s.tick && (sync_rx || (tx_mode && s.tx_busy))) begin
         n.ck_drv.out = ~s.ck_drv.out;
         if (sync_rx) begin
            if (s.ck_drv.out) begin
               n.rx_shift_register    = shifted;
               n.rx_cnt = s.rx_cnt + 4'h1;
               if (s.rx_cnt == rx_bits - 4'h1) begin
                  word_done = 1'b1;
                  word      = pack_word(shifted, s.rx9, 1'b0);
                  n.rx_cnt  = 4'h0;
                  if (!s.continuous_receive_enable) begin
                     n.single_receive_enable = 1'b0;
                  end
               end
            end
         end else if (!s.ck_drv.out) begin
            n.dt_drv.out = s.tx_shift_register[0];
            n.tx_shift_register        = {1'b0, s.tx_shift_register[8:1]};
         end else begin
            n.tx_cnt = s.tx_cnt + 4'h1;
            if (s.tx_cnt == tx_bits - 4'h1) begin
               n.tx_busy = 1'b0;
               n.tx_cnt  = 4'h0;
            end
         end
      end

      // receiver reset
      if (!s.port_enable || !rx_ovr) begin
         n.rx_st  = rx_idle;
         n.rx_cnt = 4'h0;
      end
      if (!s.port_enable) begin
         n.overrun_error = 1'b0;
      end

      // transmitter: abort, or load from the holding buffer
      if (!s.transmit_enable || !s.port_enable) begin
         n.tx_busy = 1'b0;
         n.tx_cnt  = 4'h0;
      end else if (tx_mode && !rx_ovr && !s.tx_busy && s.hold_full) begin
         n.tx_shift_register       = {s.tx_ninth_value, s.hold};
         n.tx_busy   = 1'b1;
         n.hold_full = 1'b0;
      end

      // receive fifo, pop before push
      if (pop) begin
         n.fifo[0] = s.fifo[1];
         n.fcnt    = s.fcnt - 2'h1;
      end
      if (word_done && !s.overrun_error) begin
         if (n.fcnt == `FIFO_DEPTH) begin
            n.overrun_error = 1'b1;
         end else begin
            n.fifo[n.fcnt[0]] = word;
            n.fcnt            = n.fcnt + 2'h1;
         end
      end

      // pins
      n.dt_drv.oe = tx_mode & ~rx_ovr;
      n.ck_drv.oe = s.port_enable & s.sync & s.clock_source_master & (s.transmit_enable | rx_ovr);
      if (!n.ck_drv.oe) begin
         n.ck_drv.out = 1'b0;
      end

      // interrupt gating
      n.irq = s.periph_en & ~s.glob_dis
            & ((~s.hold_full & s.tx_ie) | ((s.fcnt != 2'h0) & s.rx_ie));

      // register reads
      n.rdata = 8'h00;
      if (req.rd) begin
         if (req.addr == `OFF_FLAGS) begin
            n.rdata[`FLAG_TX] = ~s.hold_full;
            n.rdata[`FLAG_RX] = s.fcnt != 2'h0;
         end else if (req.addr == `OFF_ENABLES) begin
            n.rdata[`FLAG_TX] = s.tx_ie;
            n.rdata[`FLAG_RX] = s.rx_ie;
         end else if (req.addr == `OFF_CPU_IRQ) begin
            n.rdata[`CPU_PERIPH_EN]  = s.periph_en;
            n.rdata[`CPU_GLOBAL_DIS] = s.glob_dis;
         end else if (req.addr == `OFF_RX_STATUS) begin
            n.rdata[`RX_PORT_EN]  = s.port_enable;
            n.rdata[`RX_NINTH_EN] = s.rx9;
            n.rdata[`RX_SINGLE]   = s.single_receive_enable;
            n.rdata[`RX_CONT]     = s.continuous_receive_enable;
            n.rdata[`RX_FRAMING_ERROR]     = s.fifo[0].framing_error;
            n.rdata[`RX_OVERRUN_ERROR]     = s.overrun_error;
            n.rdata[`RX_NINTH]    = s.fifo[0].ninth;
         end else if (req.addr == `OFF_RX_DATA) begin
            n.rdata = s.fifo[0].data;
         end else if (req.addr == `OFF_TX_STATUS) begin
            n.rdata[`TX_CLK_MASTER] = s.clock_source_master;
            n.rdata[`TX_NINTH_EN]   = s.tx9;
            n.rdata[`TX_EN]         = s.transmit_enable;
            n.rdata[`TX_SYNC]       = s.sync;
            n.rdata[`TX_EMPTY]      = ~s.tx_busy;
            n.rdata[`TX_NINTH]      = s.tx_ninth_value;
         end else if (req.addr == `OFF_TX_HOLD) begin
            n.rdata = s.hold;
         end else if (req.addr == `OFF_BAUD) begin
            n.rdata = s.baud_div;
         end
      end

      // register writes, after hardware updates so software sets win
      if (req.wr) begin
         if (req.addr == `OFF_ENABLES) begin
            n.tx_ie = req.wdata[`FLAG_TX];
            n.rx_ie = req.wdata[`FLAG_RX];
         end else if (req.addr == `OFF_CPU_IRQ) begin
            n.periph_en = req.wdata[`CPU_PERIPH_EN];
            n.glob_dis  = req.wdata[`CPU_GLOBAL_DIS];
         end else if (req.addr == `OFF_RX_STATUS) begin
            n.port_enable = req.wdata[`RX_PORT_EN];
            n.rx9  = req.wdata[`RX_NINTH_EN];
            n.single_receive_enable = req.wdata[`RX_SINGLE];
            n.continuous_receive_enable = req.wdata[`RX_CONT];
            if (s.continuous_receive_enable && !req.wdata[`RX_CONT]) begin
               n.overrun_error = n.overrun_error & ~s.overrun_error;
            end
         end else if (req.addr == `OFF_TX_STATUS) begin
            n.clock_source_master = req.wdata[`TX_CLK_MASTER];
            n.tx9  = req.wdata[`TX_NINTH_EN];
            n.transmit_enable = req.wdata[`TX_EN];
            n.sync = req.wdata[`TX_SYNC];
            n.tx_ninth_value = req.wdata[`TX_NINTH];
         end else if (req.addr == `OFF_TX_HOLD) begin
            n.hold      = req.wdata;
            n.hold_full = 1'b1;
         end else if (req.addr == `OFF_BAUD) begin
            n.baud_div = req.wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign rdata  = s.rdata;
   assign dt_drv = s.dt_drv;
   assign ck_drv = s.ck_drv;
   assign irq    = s.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence load_cond;
      tx_mode && !rx_ovr && !s.tx_busy && s.hold_full
      && !(req.wr && req.addr == `OFF_TX_HOLD);
   endsequence

   sequence single_done;
      word_done && sync_rx && s.single_receive_enable && !s.continuous_receive_enable && !req.wr;
   endsequence

   a_baud_held_off: assert property (!(s.transmit_enable || s.continuous_receive_enable || s.single_receive_enable) |=> !s.tick)
      else $error("baud tick while generator held");
   a_false_start: assert property (s.tick && rx_on && s.rx_st == rx_start
      && s.ovs == `SAMPLE_LAST && lvl |=> s.rx_st == rx_idle)
      else $error("majority high start not rejected");
   a_sample_window: assert property ($changed(s.votes) |->
      $past(s.tick) && ($past(s.ovs) == 4'h6 || $past(s.ovs) == 4'h7))
      else $error("vote sample outside ticks seven and eight");
   a_phase_step: assert property (s.tick && rx_on && s.rx_st != rx_idle
      && !(!s.port_enable || !s.continuous_receive_enable) |=> s.ovs == $past(s.ovs) + 4'h1)
      else $error("oversampling phase did not advance");
   a_rx_idle_reset: assert property (!s.port_enable |=> s.rx_st == rx_idle)
      else $error("receiver not idle with port disabled");
   a_dt_released: assert property (s.continuous_receive_enable || s.single_receive_enable |=> !s.dt_drv.oe)
      else $error("data pin driven during reception");
   a_pins_float: assert property (!s.transmit_enable && !s.continuous_receive_enable && !s.single_receive_enable
      |=> !s.ck_drv.oe && !s.dt_drv.oe)
      else $error("pins driven with all enables clear");
   a_load_hold: assert property (load_cond |=> s.tx_busy && !s.hold_full)
      else $error("holding buffer not moved to shift register");
   a_overrun_set: assert property (word_done && s.fcnt == `FIFO_DEPTH && !pop
      && !s.overrun_error |=> s.overrun_error && s.fcnt == `FIFO_DEPTH)
      else $error("overrun not flagged on full fifo");
   a_irq_gated: assert property (s.irq |-> $past(s.periph_en) && !$past(s.glob_dis))
      else $error("interrupt raised while gated off");
   a_single_clear: assert property (single_done |=> !s.single_receive_enable)
      else $error("single receive enable not cleared");
   a_flag_write_only: assert property (!s.hold_full
      && !(req.wr && req.addr == `OFF_TX_HOLD) |=> !s.hold_full)
      else $error("transmit flag cleared without a buffer write");
   a_tx_abort: assert property (!s.transmit_enable |=> !s.tx_busy && s.tx_cnt == 4'h0)
      else $error("transmitter not reset with transmit disabled");
   a_half_duplex: assert property (sync_rx |=> $stable(s.tx_shift_register))
      else $error("shift register moved during reception");
   a_rx_irq: assert property (s.fcnt != 2'h0 && s.rx_ie
      && s.periph_en && !s.glob_dis |=> s.irq)
      else $error("receive interrupt not raised");
   a_ck_master: assert property (tx_mode |=> s.ck_drv.oe)
      else $error("clock pin not driven in master mode");
   a_empty_status: assert property (req.rd && req.addr == `OFF_TX_STATUS
      |=> s.rdata[`TX_EMPTY] == !$past(s.tx_busy))
      else $error("shift empty status does not follow shift register");

endmodule

// *** usart_consts.svh ***
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// register offsets
`define OFF_FLAGS      8'h10
`define OFF_ENABLES    8'h11
`define OFF_CPU_IRQ    8'h12
`define OFF_RX_STATUS  8'h13
`define OFF_RX_DATA    8'h14
`define OFF_TX_STATUS  8'h15
`define OFF_TX_HOLD    8'h16
`define OFF_BAUD       8'h17

// receive status and control fields
`define RX_PORT_EN     7
`define RX_NINTH_EN    6
`define RX_SINGLE      5
`define RX_CONT        4
`define RX_FRAMING_ERROR        2
`define RX_OVERRUN_ERROR        1
`define RX_NINTH       0

// transmit status and control fields
`define TX_CLK_MASTER  7
`define TX_NINTH_EN    6
`define TX_EN          5
`define TX_SYNC        4
`define TX_EMPTY       1
`define TX_NINTH       0

// flag, enable and cpu fields
`define FLAG_TX        1
`define FLAG_RX        0
`define CPU_PERIPH_EN  0
`define CPU_GLOBAL_DIS 1

// reset values (all state clears; empty buffer reads as flag 1)
`define RST_FLAGS      8'h02
`define RST_TX_STATUS  8'h02

// oversampling and frame counts
`define SAMPLE_FIRST   4'h6
`define SAMPLE_LAST    4'h8
`define BITS_SHORT     4'h8
`define BITS_LONG      4'h9
`define FIFO_DEPTH     2'h2

`endif

// *** usart_pkg.sv ***
package usart_pkg;

   typedef enum logic [1:0] {rx_idle, rx_start, rx_data} rx_phase_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_out_t;

   typedef struct packed {
      logic       framing_error;
      logic       ninth;
      logic [7:0] data;
   } rx_word_t;

   typedef struct packed {
      logic           port_enable;
      logic           rx9;
      logic           single_receive_enable;
      logic           continuous_receive_enable;
      logic           overrun_error;
      logic           clock_source_master;
      logic           tx9;
      logic           transmit_enable;
      logic           sync;
      logic           tx_ninth_value;
      logic           tx_ie;
      logic           rx_ie;
      logic           periph_en;
      logic           glob_dis;
      logic [7:0]     baud_div;
      logic [7:0]     baud_cnt;
      logic           tick;
      logic [7:0]     hold;
      logic           hold_full;
      logic [8:0]     tx_shift_register;
      logic           tx_busy;
      logic [3:0]     tx_cnt;
      logic [3:0]     ovs;
      logic [1:0]     votes;
      rx_phase_t      rx_st;
      logic [8:0]     rx_shift_register;
      logic [3:0]     rx_cnt;
      rx_word_t [1:0] fifo;
      logic [1:0]     fcnt;
      logic [1:0]     dt_sync;
      pin_out_t       dt_drv;
      pin_out_t       ck_drv;
      logic [7:0]     rdata;
      logic           irq;
   } state_t;

endpackage

// *** usart_peer.sv ***
`timescale 1ns/1ns
module usart_peer (
   // bit timing
   input  wire logic clk,
   // serial lines
   input  wire logic ck,
   input  wire logic dt_oe,
   input  wire logic dt_out,
   output      logic dt_line
);
   logic        drive = 1'b0;
   logic        lvl = 1'b1;
   logic        sync_tx = 1'b0;
   logic [7:0]  shout = 8'h00;
   logic [15:0] got = 16'h0000;
   int          cnt = 0;
   int          left = 0;

   // released line rests at the pull-up level
   assign dt_line = dt_oe ? dt_out : (drive ? lvl : 1'b1);

   // capture driven data on falling shift clock
   always @(negedge ck) begin
      if (dt_oe) begin
         got <= {dt_line, got[15:1]};
         cnt <= cnt + 1;
      end
      if (sync_tx && left == 1) begin
         sync_tx <= 1'b0;
         drive <= 1'b0;
      end
      left <= left - 1;
   end

   // answer changes on rising shift clock
   always @(posedge ck) begin
      if (sync_tx) begin
         lvl <= shout[0];
         shout <= shout >> 1;
      end
   end

   task automatic clear();
      cnt = 0;
      got = 16'h0000;
   endtask

   task automatic start_sync(input logic [7:0] s);
      shout = s;
      left = 8;
      sync_tx = 1'b1;
      drive = 1'b1;
   endtask

   // one async frame, 16 clocks a bit, optional one-clock spike mid-bit
   task automatic send(input logic [8:0] w, input int nb, input logic stop, input logic gl);
      logic b;
      @(posedge clk);
      drive <= 1'b1;
      for (int i = 0; i < nb + 2; i++) begin
         b = (i == 0) ? 1'b0 : ((i > nb) ? stop : w[i-1]);
         lvl <= b;
         repeat (8) @(posedge clk);
         lvl <= b ^ (gl && i <= nb);
         @(posedge clk);
         lvl <= b;
         repeat (7) @(posedge clk);
      end
      drive <= 1'b0;
   endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ns
`include "usart_consts.svh"
module tb;
   import usart_pkg::*;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   reg_req_t   req = '0;
   logic [7:0] rdata;
   logic       dt_line;
   pin_out_t   dt_drv;
   pin_out_t   ck_drv;
   logic       irq;
   logic       pin_ck;
   int         mismatches = 0;
   int         checks = 0;

   always #5 clk = ~clk;
   // clock pin pulled low while released
   assign pin_ck = ck_drv.oe ? ck_drv.out : 1'b0;

   usart_rx_sampling_sync_master_tx uut (
      .clk    (clk),
      .reset  (reset),
      .req    (req),
      .rdata  (rdata),
      .dt_in  (dt_line),
      .dt_drv (dt_drv),
      .ck_drv (ck_drv),
      .irq    (irq)
   );

   usart_peer peer (
      .clk     (clk),
      .ck      (pin_ck),
      .dt_oe   (dt_drv.oe),
      .dt_out  (dt_drv.out),
      .dt_line (dt_line)
   );

   task automatic summarize();
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(16'(rdata & m), 16'(e));
   endtask

   task automatic wait_bits(input int n);
      for (int k = 0; k < 1000 && peer.cnt < n; k++)
         @(posedge clk);
      tick(3);
      chk(16'(peer.cnt), 16'(n));
   endtask

   task automatic t_regs();
      rd(`OFF_FLAGS, `RST_FLAGS);
      rd(`OFF_TX_STATUS, `RST_TX_STATUS);
      rd(8'h20, 8'h00);
      wr(`OFF_FLAGS, 8'h00);
      wr(`OFF_TX_STATUS, 8'h00);
      rd(`OFF_FLAGS, 8'h02);
      rd(`OFF_TX_STATUS, 8'h02);
      wr(`OFF_CPU_IRQ, 8'h01);
      wr(`OFF_ENABLES, 8'h02);
      tick(2);
      chk(16'(irq), 16'h1);
      wr(`OFF_CPU_IRQ, 8'h03);
      tick(2);
      chk(16'(irq), 16'h0);
      wr(`OFF_CPU_IRQ, 8'h01);
      wr(`OFF_ENABLES, 8'h01);
      tick(2);
      chk(16'(irq), 16'h0);
   endtask

   task automatic t_async();
      wr(`OFF_BAUD, 8'h00);
      wr(`OFF_RX_STATUS, 8'h90);
      peer.send(9'h0a5, 8, 1'b1, 1'b1);
      tick(4);
      chk(16'(irq), 16'h1);
      rd(`OFF_FLAGS, 8'h03);
      rd(`OFF_RX_STATUS, 8'h90);
      rd(`OFF_RX_DATA, 8'ha5);
      peer.send(9'h03c, 8, 1'b0, 1'b0);
      tick(4);
      rd(`OFF_RX_STATUS, 8'h94);
      rd(`OFF_RX_DATA, 8'h3c);
      fork
         peer.send(9'h077, 8, 1'b1, 1'b0);
         wr(`OFF_RX_STATUS, 8'h80);
      join
      wr(`OFF_RX_STATUS, 8'h90);
      peer.send(9'h066, 8, 1'b1, 1'b0);
      tick(4);
      rd(`OFF_RX_DATA, 8'h66);
      rd(`OFF_FLAGS, 8'h02);
      wr(`OFF_RX_STATUS, 8'hd0);
      peer.send(9'h1c3, 9, 1'b1, 1'b0);
      tick(4);
      rd(`OFF_RX_STATUS, 8'hd1);
      rd(`OFF_RX_DATA, 8'hc3);
      wr(`OFF_RX_STATUS, 8'h90);
   endtask

   task automatic t_overrun();
      peer.send(9'h011, 8, 1'b1, 1'b0);
      peer.send(9'h022, 8, 1'b1, 1'b0);
      peer.send(9'h033, 8, 1'b1, 1'b0);
      tick(4);
      rd(`OFF_RX_STATUS, 8'h92);
      rd(`OFF_RX_DATA, 8'h11);
      rd(`OFF_RX_DATA, 8'h22);
      rd(`OFF_FLAGS, 8'h02);
      wr(`OFF_RX_STATUS, 8'h80);
      rd(`OFF_RX_STATUS, 8'h80, 8'hfa);
   endtask

   task automatic t_sync_tx();
      wr(`OFF_BAUD, 8'h07);
      rd(`OFF_BAUD, 8'h07);
      wr(`OFF_TX_STATUS, 8'hb0);
      tick(2);
      chk(16'(ck_drv.oe), 16'h1);
      peer.clear();
      wr(`OFF_TX_HOLD, 8'h3c);
      wr(`OFF_TX_HOLD, 8'hc3);
      rd(`OFF_FLAGS, 8'h00, 8'h02);
      wait_bits(16);
      chk(peer.got, 16'hc33c);
      rd(`OFF_TX_STATUS, 8'h02, 8'h02);
      rd(`OFF_TX_HOLD, 8'hc3);
      rd(`OFF_FLAGS, 8'h02);
      wr(`OFF_TX_STATUS, 8'hf1);
      peer.clear();
      wr(`OFF_TX_HOLD, 8'ha5);
      wait_bits(9);
      chk(16'(peer.got[15:7]), 16'h01a5);
   endtask

   task automatic t_abort();
      wr(`OFF_TX_STATUS, 8'hb0);
      peer.clear();
      wr(`OFF_TX_HOLD, 8'h0f);
      wait_bits(3);
      wr(`OFF_TX_STATUS, 8'h90);
      tick(2);
      chk(16'(dt_drv.oe), 16'h0);
      chk(16'(ck_drv.oe), 16'h0);
      rd(`OFF_TX_STATUS, 8'h02, 8'h02);
   endtask

   task automatic t_single_rx();
      wr(`OFF_TX_STATUS, 8'hb0);
      peer.clear();
      wr(`OFF_TX_HOLD, 8'h81);
      wait_bits(2);
      @(negedge pin_ck);
      #1;
      peer.start_sync(8'h5a);
      wr(`OFF_RX_STATUS, 8'ha0);
      tick(2);
      chk(16'(dt_drv.oe), 16'h0);
      chk(16'(ck_drv.oe), 16'h1);
      for (int k = 0; k < 1000 && peer.sync_tx; k++)
         @(posedge clk);
      tick(4);
      chk(16'(dt_drv.oe), 16'h1);
      rd(`OFF_RX_STATUS, 8'h00, 8'h20);
      rd(`OFF_RX_DATA, 8'h5a);
      wr(`OFF_TX_STATUS, 8'h00);
   endtask

   initial begin
      #500000;
      mismatches++;
      summarize();
   end

   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_async();
      t_overrun();
      t_sync_tx();
      t_abort();
      t_single_rx();
      summarize();
   end
endmodule
